//--- adc_capture_trigger_window_buffer.sv
// Summary of operation
// - capture sample plus overflow into 15x13 fifo
// - main clock drains fifo into primary buffer
// - read enable follows fifo not-empty
// - primary ring addresses 0..4080 then wraps
// - per trigger copy window, time, trigger number
// - secondary memory holds 2040 words
// - trigger queue 16 bits, timestamp, pointer and trigger number
// - timestamp in four entries, low slice first
// - first slice tag 1100, others 0100
// - queue not-empty flag starts copy machine
// - copy starts at queued ring address
// - copy stops at window length count
// - ready count up per copy, down by consumer
// - block start addresses fixed by block end location
// - four timestamp words tag 1000, msb first
// - trigger number hi tag 010, lo 01
// - samples tag 000, last sample 001
// - decrement applies before increment
// - copy overrun sticky until reset
// - block overrun sticky at programmed maximum
`timescale 1ns/10ps
`include "capture_buffer_defs.svh"

module adc_capture_trigger_window_buffer #(
  parameter int TQ_DEPTH = `TQ_DEPTH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic softReset_n,
  input wire logic converterOutputClock,
  input wire logic [`SAMPLE_BITS-1:0] converterSample,
  input wire logic converterOverflow,
  input wire logic triggerPulse,
  input wire logic [`TS_BITS-1:0] timestamp,
  input wire logic [`TN_BITS-1:0] triggerNumber,
  input wire logic [`SEC_ADDR_BITS-1:0] triggerWindowLength,
  input wire logic [`SEC_ADDR_BITS-1:0] blockEndLocation,
  input wire logic [`COUNT_BITS-1:0] maxReadyBlocks,
  input wire logic blockDone,
  input wire logic [`SEC_ADDR_BITS-1:0] secReadAddr,
  output logic [`SEC_WORD_BITS-1:0] secReadData_r,
  output logic [`COUNT_BITS-1:0] readyBlockCount_r,
  output logic triggerQueueStatusFlag_r,
  output logic copyOverrunFlag_r,
  output logic blockOverrunFlag_r
);

  localparam int TQ_AW = $clog2(TQ_DEPTH);

  // ==========================================================
  // converter clock domain: capture fifo write side
  // ==========================================================
  logic [`CAP_WORD_BITS-1:0] capMem [16];
  logic [1:0] convRstSync_r;
  logic [`CAP_PTR_BITS-1:0] capWrBin_r;
  logic [`CAP_PTR_BITS-1:0] capWrGray_r;
  logic [`CAP_PTR_BITS-1:0] capRdGray_r;
  logic [`CAP_PTR_BITS-1:0] rdGraySync1_r;
  logic [`CAP_PTR_BITS-1:0] rdGraySync2_r;
  logic [`CAP_PTR_BITS-1:0] rdBinInConv;
  logic [`CAP_PTR_BITS-1:0] capFill;
  logic capFull;
  logic [`CAP_PTR_BITS-1:0] capWrBinNxt;

  function automatic logic [`CAP_PTR_BITS-1:0] grayToBin(input logic [`CAP_PTR_BITS-1:0] g);
    logic [`CAP_PTR_BITS-1:0] b;
    b[`CAP_PTR_BITS-1] = g[`CAP_PTR_BITS-1];
    for (int i = `CAP_PTR_BITS-2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction : grayToBin

  // local reset release for the converter domain
  always_ff @(posedge converterOutputClock or negedge reset_n) begin
    if (!reset_n) begin
      convRstSync_r <= 2'h0;
    end else begin
      convRstSync_r <= {convRstSync_r[0], 1'b1};
    end
  end

  // read pointer brought over in gray
  always_ff @(posedge converterOutputClock or negedge reset_n) begin
    if (!reset_n) begin
      rdGraySync1_r <= '0;
      rdGraySync2_r <= '0;
    end else begin
      rdGraySync1_r <= capRdGray_r;
      rdGraySync2_r <= rdGraySync1_r;
    end
  end

  assign rdBinInConv = grayToBin(rdGraySync2_r);
  assign capFill = capWrBin_r - rdBinInConv;
  assign capFull = (capFill >= 5'(`CAP_FIFO_DEPTH));
  assign capWrBinNxt = capWrBin_r + 5'h01;

  // sample and overflow on the converter's clock
  always_ff @(posedge converterOutputClock or negedge reset_n) begin
    if (!reset_n) begin
      capWrBin_r <= '0;
      capWrGray_r <= '0;
    end else if (convRstSync_r[1] && !capFull) begin
      capWrBin_r <= capWrBinNxt;
      capWrGray_r <= capWrBinNxt ^ (capWrBinNxt >> 1);
    end
  end

  always_ff @(posedge converterOutputClock) begin
    if (convRstSync_r[1] && !capFull) begin
      capMem[capWrBin_r[3:0]] <= {converterOverflow, converterSample};
    end
  end

  // ==========================================================
  // main clock domain: capture fifo read side
  // ==========================================================
  logic [`CAP_PTR_BITS-1:0] capRdBin_r;
  logic [`CAP_PTR_BITS-1:0] wrGraySync1_r;
  logic [`CAP_PTR_BITS-1:0] wrGraySync2_r;
  logic [`CAP_PTR_BITS-1:0] capRdBinNxt;
  logic capEmpty;
  logic capRead;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrGraySync1_r <= '0;
      wrGraySync2_r <= '0;
    end else begin
      wrGraySync1_r <= capWrGray_r;
      wrGraySync2_r <= wrGraySync1_r;
    end
  end

  assign capEmpty = (capRdGray_r == wrGraySync2_r);
  assign capRead = !capEmpty;
  assign capRdBinNxt = capRdBin_r + 5'h01;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      capRdBin_r <= '0;
      capRdGray_r <= '0;
    end else if (capRead) begin
      capRdBin_r <= capRdBinNxt;
      capRdGray_r <= capRdBinNxt ^ (capRdBinNxt >> 1);
    end
  end

  // ==========================================================
  // primary ring buffer
  // ==========================================================
  logic [`CAP_WORD_BITS-1:0] priMem [`PRI_LAST_ADDR+1];
  logic [`PRI_ADDR_BITS-1:0] priWrPtr_r;
  logic [`PRI_ADDR_BITS-1:0] priWrPtrNxt;
  logic [`CAP_WORD_BITS-1:0] priRdData_r;
  logic [`PRI_ADDR_BITS-1:0] priRdAddr_r;

  // wrap after the last ring address
  assign priWrPtrNxt = (priWrPtr_r == `PRI_LAST_ADDR) ? '0 : priWrPtr_r + 12'h001;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      priWrPtr_r <= '0;
    end else if (capRead) begin
      priWrPtr_r <= priWrPtrNxt;
    end
  end

  always_ff @(posedge clk) begin
    if (capRead) begin
      priMem[priWrPtr_r] <= capMem[capRdBin_r[3:0]];
    end
    priRdData_r <= priMem[priRdAddr_r];
  end

  // ==========================================================
  // trigger queue
  // ==========================================================
  logic [`TQ_WORD_BITS-1:0] tqMem [TQ_DEPTH];
  logic [TQ_AW:0] tqWr_r;
  logic [TQ_AW:0] tqRd_r;
  logic [TQ_AW:0] tqUsed;
  logic [2:0] pushCnt_r;
  logic [`TS_BITS-1:0] tsHold_r;
  logic [`TN_BITS-1:0] tnHold_r;
  logic [`PRI_ADDR_BITS-1:0] ptrHold_r;
  logic [`TQ_WORD_BITS-1:0] pushWord;
  logic pushing;
  logic tqEmpty;
  logic tqPop;
  logic trigAccept;
  logic trigLost;
  logic [`TQ_WORD_BITS-1:0] tqHead;

  assign tqUsed = tqWr_r - tqRd_r;
  assign tqEmpty = (tqUsed == '0);
  assign tqHead = tqMem[tqRd_r[TQ_AW-1:0]];
  assign pushing = (pushCnt_r != 3'h0);
  // lost when still pushing or no room
  assign trigAccept = triggerPulse && !pushing
    && ((TQ_AW+1)'(TQ_DEPTH) - tqUsed >= (TQ_AW+1)'(`TQ_ENTRIES_PER_TRIG));
  assign trigLost = triggerPulse && !trigAccept;

  // low slice first; window start tag
  assign pushWord =
    (pushCnt_r == 3'h7) ? {`TAG_QUEUE_TS_FIRST, tsHold_r[11:0]} :
    (pushCnt_r == 3'h6) ? {`TAG_QUEUE_TS_REST, tsHold_r[23:12]} :
    (pushCnt_r == 3'h5) ? {`TAG_QUEUE_TS_REST, tsHold_r[35:24]} :
    (pushCnt_r == 3'h4) ? {`TAG_QUEUE_TS_REST, tsHold_r[47:36]} :
    (pushCnt_r == 3'h3) ? {`TAG_QUEUE_PTR, ptrHold_r} :
    (pushCnt_r == 3'h2) ? {`TAG_SEC_TN_HI, tnHold_r[26:14]} :
    {`TAG_SEC_TN_LO, tnHold_r[13:0]};

  // latch time and ring pointer at the trigger
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pushCnt_r <= 3'h0;
      tsHold_r <= '0;
      tnHold_r <= '0;
      ptrHold_r <= '0;
    end else if (trigAccept) begin
      pushCnt_r <= `TQ_ENTRIES_PER_TRIG;
      tsHold_r <= timestamp;
      tnHold_r <= triggerNumber;
      ptrHold_r <= priWrPtr_r;
    end else if (pushing) begin
      pushCnt_r <= pushCnt_r - 3'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tqWr_r <= '0;
      tqRd_r <= '0;
      triggerQueueStatusFlag_r <= 1'b0;
    end else begin
      if (pushing) begin
        tqWr_r <= tqWr_r + 1'b1;
      end
      if (tqPop) begin
        tqRd_r <= tqRd_r + 1'b1;
      end
      triggerQueueStatusFlag_r <= !tqEmpty;
    end
  end

  always_ff @(posedge clk) begin
    if (pushing) begin
      tqMem[tqWr_r[TQ_AW-1:0]] <= pushWord;
    end
  end

  // ==========================================================
  // copy engine
  // ==========================================================
  capture_buffer_pkg::copy_state_type state_r;
  capture_buffer_pkg::copy_state_type state_nxt;
  logic [2:0] hdrCnt_r;
  logic [`SEC_ADDR_BITS-1:0] issued_r;
  logic [`SEC_ADDR_BITS-1:0] written_r;
  logic readPend_r;
  logic [`SEC_ADDR_BITS-1:0] blockBase_r;
  logic [`SEC_ADDR_BITS:0] nextBase;
  logic canIssue;
  logic issue;
  logic copyInc;
  logic secWe;
  logic [`SEC_ADDR_BITS-1:0] secWaddr;
  logic [`SEC_WORD_BITS-1:0] secWdata;
  logic hdrWrite;
  logic lastSample;
  logic [`SEC_WORD_BITS-1:0] secMem [`SEC_WORDS];

  // queue flag kicks the engine off
  assign tqPop = (state_r == capture_buffer_pkg::CP_HEADER) && !tqEmpty;
  assign hdrWrite = tqPop && (hdrCnt_r != 3'h4);
  // stop issuing at the window length
  assign canIssue = (issued_r != triggerWindowLength) && (priRdAddr_r != priWrPtr_r);
  assign issue = (state_r == capture_buffer_pkg::CP_COPY) && canIssue;
  assign lastSample = (written_r == triggerWindowLength - 11'h001);
  assign nextBase = {1'b0, blockBase_r} + {1'b0, blockEndLocation} + 12'h001;
  assign copyInc = (state_r == capture_buffer_pkg::CP_DONE);

  // ts msb slice at the lowest address
  assign secWe = hdrWrite || readPend_r;
  assign secWaddr =
    readPend_r ? blockBase_r + `SEC_HDR_WORDS + written_r :
    (hdrCnt_r < 3'h4) ? blockBase_r + 11'(3'h3 - hdrCnt_r) :
    blockBase_r + 11'(hdrCnt_r - 3'h1);
  // trigger number words already tagged in queue
  assign secWdata =
    readPend_r ? {(lastSample ? `TAG_SEC_LAST : `TAG_SEC_SAMPLE), priRdData_r} :
    (hdrCnt_r < 3'h4) ? {`TAG_SEC_TS, tqHead[11:0]} : tqHead;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      capture_buffer_pkg::CP_IDLE: begin
        if (triggerQueueStatusFlag_r && !tqEmpty) begin
          state_nxt = capture_buffer_pkg::CP_HEADER;
        end
      end
      capture_buffer_pkg::CP_HEADER: begin
        if (tqPop && hdrCnt_r == 3'h6) begin
          state_nxt = capture_buffer_pkg::CP_COPY;
        end
      end
      capture_buffer_pkg::CP_COPY: begin
        if (issued_r == triggerWindowLength) begin
          state_nxt = capture_buffer_pkg::CP_DRAIN;
        end
      end
      capture_buffer_pkg::CP_DRAIN: begin
        if (!readPend_r) begin
          state_nxt = capture_buffer_pkg::CP_DONE;
        end
      end
      capture_buffer_pkg::CP_DONE: begin
        state_nxt = capture_buffer_pkg::CP_IDLE;
      end
    endcase
  end

  // first read address from the queue
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= capture_buffer_pkg::CP_IDLE;
      hdrCnt_r <= 3'h0;
      priRdAddr_r <= '0;
      issued_r <= '0;
      written_r <= '0;
      readPend_r <= 1'b0;
      blockBase_r <= '0;
    end else begin
      state_r <= state_nxt;
      readPend_r <= issue;
      if (state_r == capture_buffer_pkg::CP_IDLE) begin
        hdrCnt_r <= 3'h0;
        issued_r <= '0;
        written_r <= '0;
      end else if (tqPop) begin
        hdrCnt_r <= hdrCnt_r + 3'h1;
      end
      if (tqPop && hdrCnt_r == 3'h4) begin
        priRdAddr_r <= tqHead[`PRI_ADDR_BITS-1:0];
      end else if (issue) begin
        priRdAddr_r <= (priRdAddr_r == `PRI_LAST_ADDR) ? '0 : priRdAddr_r + 12'h001;
      end
      if (issue) begin
        issued_r <= issued_r + 11'h001;
      end
      if (readPend_r) begin
        written_r <= written_r + 11'h001;
      end
      // next block start, wrap inside 2040 words
      if (copyInc) begin
        blockBase_r <= (nextBase + {1'b0, blockEndLocation} + 12'h001 > 12'(`SEC_WORDS)) ?
          '0 : nextBase[`SEC_ADDR_BITS-1:0];
      end
    end
  end

  // secondary memory write and consumer read
  always_ff @(posedge clk) begin
    if (secWe) begin
      secMem[secWaddr] <= secWdata;
    end
    secReadData_r <= secMem[secReadAddr];
  end

  // ==========================================================
  // ready-block count and overrun flags
  // ==========================================================
  logic [`COUNT_BITS-1:0] afterDec;
  logic [`COUNT_BITS-1:0] countNxt;

  assign afterDec = (blockDone && readyBlockCount_r != '0) ? readyBlockCount_r - 4'h1 : readyBlockCount_r;
  assign countNxt = copyInc ? afterDec + 4'h1 : afterDec;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      readyBlockCount_r <= '0;
    end else begin
      readyBlockCount_r <= countNxt;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      copyOverrunFlag_r <= 1'b0;
      blockOverrunFlag_r <= 1'b0;
    end else if (!softReset_n) begin
      copyOverrunFlag_r <= 1'b0;
      blockOverrunFlag_r <= 1'b0;
    end else begin
      copyOverrunFlag_r <= copyOverrunFlag_r || trigLost;
      blockOverrunFlag_r <= blockOverrunFlag_r || (readyBlockCount_r == maxReadyBlocks);
    end
  end

endmodule : adc_capture_trigger_window_buffer

//--- adc_capture_trigger_window_buffer_asserts.sv
`timescale 1ns/10ps
`include "capture_buffer_defs.svh"
// ==========================================
// output checks of the capture buffer
module cap_buffer_checker #(
  parameter int TQ_DEPTH = `TQ_DEPTH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic softReset_n,
  input wire logic converterOutputClock,
  input wire logic [`SAMPLE_BITS-1:0] converterSample,
  input wire logic converterOverflow,
  input wire logic triggerPulse,
  input wire logic [`TS_BITS-1:0] timestamp,
  input wire logic [`TN_BITS-1:0] triggerNumber,
  input wire logic [`SEC_ADDR_BITS-1:0] triggerWindowLength,
  input wire logic [`SEC_ADDR_BITS-1:0] blockEndLocation,
  input wire logic [`COUNT_BITS-1:0] maxReadyBlocks,
  input wire logic blockDone,
  input wire logic [`SEC_ADDR_BITS-1:0] secReadAddr,
  input wire logic [`SEC_WORD_BITS-1:0] secReadData_r,
  input wire logic [`COUNT_BITS-1:0] readyBlockCount_r,
  input wire logic triggerQueueStatusFlag_r,
  input wire logic copyOverrunFlag_r,
  input wire logic blockOverrunFlag_r
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // ==========================================
  // ready count, queue flag and overrun flags
  chk_count_step: assert property (
    $changed(readyBlockCount_r) |-> (readyBlockCount_r == $past(readyBlockCount_r) + 4'h1) ||
      (readyBlockCount_r == $past(readyBlockCount_r) - 4'h1))
    else $error("ready count jumped by more than one");
  chk_done_order: assert property (
    blockDone && readyBlockCount_r != 4'h0 |=> (readyBlockCount_r == $past(readyBlockCount_r)) ||
      (readyBlockCount_r == $past(readyBlockCount_r) - 4'h1))
    else $error("decrement not applied before increment");
  chk_zero_floor: assert property (
    blockDone && readyBlockCount_r == 4'h0 |=> readyBlockCount_r <= 4'h1)
    else $error("ready count went below zero");
  chk_copy_sticky: assert property (
    copyOverrunFlag_r && softReset_n |=> copyOverrunFlag_r)
    else $error("copy overrun flag dropped without reset");
  chk_block_sticky: assert property (
    blockOverrunFlag_r && softReset_n |=> blockOverrunFlag_r)
    else $error("block overrun flag dropped without reset");
  chk_block_set: assert property (
    readyBlockCount_r == maxReadyBlocks && softReset_n |-> ##[1:2] blockOverrunFlag_r)
    else $error("block overrun flag not set at maximum");
  chk_soft_clear: assert property (
    !softReset_n |=> !copyOverrunFlag_r && !blockOverrunFlag_r)
    else $error("soft reset did not clear overrun flags");
  chk_flag_cause: assert property (
    $rose(triggerQueueStatusFlag_r) |-> $past(triggerPulse, 1) || $past(triggerPulse, 2) ||
      $past(triggerPulse, 3) || $past(triggerPulse, 4))
    else $error("queue flag rose without trigger");
  chk_overrun_cause: assert property (
    $rose(copyOverrunFlag_r) |-> $past(triggerPulse))
    else $error("copy overrun without trigger");

  // main scenarios reached
  cover property ($rose(blockOverrunFlag_r));
  cover property ($rose(copyOverrunFlag_r));
  cover property (blockDone && readyBlockCount_r == 4'h0);
endmodule : cap_buffer_checker

bind adc_capture_trigger_window_buffer cap_buffer_checker #(.TQ_DEPTH(TQ_DEPTH)) chkU (
  .clk(clk), .reset_n(reset_n), .softReset_n(softReset_n), .converterOutputClock(converterOutputClock),
  .converterSample(converterSample), .converterOverflow(converterOverflow), .triggerPulse(triggerPulse),
  .timestamp(timestamp), .triggerNumber(triggerNumber), .triggerWindowLength(triggerWindowLength),
  .blockEndLocation(blockEndLocation), .maxReadyBlocks(maxReadyBlocks), .blockDone(blockDone),
  .secReadAddr(secReadAddr), .secReadData_r(secReadData_r), .readyBlockCount_r(readyBlockCount_r),
  .triggerQueueStatusFlag_r(triggerQueueStatusFlag_r), .copyOverrunFlag_r(copyOverrunFlag_r),
  .blockOverrunFlag_r(blockOverrunFlag_r));

//--- adc_capture_trigger_window_buffer_bench.sv
`timescale 1ns/10ps
// ==========================================
// bench: 8-sample windows, 14-word blocks, then one 200-sample wrap window
module adc_capture_trigger_window_buffer_bench;
  logic clk, reset_n, softReset_n, convClk, convOvf, triggerPulse, blockDone, tqFlag, copyOvr, blockOvr;
  logic [11:0] convSample;
  logic [47:0] timestamp;
  logic [26:0] triggerNumber;
  logic [10:0] secReadAddr, winLen, blockEnd;
  logic [15:0] secReadData;
  logic [3:0] maxReadyBlocks, readyCount;
  int nFail, checks, cycles;

  converter_model convU (.converterOutputClock(convClk), .converterSample(convSample),
    .converterOverflow(convOvf));
  adc_capture_trigger_window_buffer dut_u (.clk(clk), .reset_n(reset_n), .softReset_n(softReset_n),
    .converterOutputClock(convClk), .converterSample(convSample), .converterOverflow(convOvf),
    .triggerPulse(triggerPulse), .timestamp(timestamp), .triggerNumber(triggerNumber),
    .triggerWindowLength(winLen), .blockEndLocation(blockEnd), .maxReadyBlocks(maxReadyBlocks),
    .blockDone(blockDone), .secReadAddr(secReadAddr), .secReadData_r(secReadData),
    .readyBlockCount_r(readyCount), .triggerQueueStatusFlag_r(tqFlag), .copyOverrunFlag_r(copyOvr),
    .blockOverrunFlag_r(blockOvr));

  // main clock and hang limit
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      nFail++;
      complete_run();
    end
  end

  task check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      nFail++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task read_sec(input logic [10:0] a, output logic [15:0] d);
    @(posedge clk) secReadAddr <= a;
    @(posedge clk);
    #1 d = secReadData;
  endtask : read_sec

  task fire(input logic [47:0] ts, input logic [26:0] tn);
    @(posedge clk);
    triggerPulse <= 1'b1;
    timestamp <= ts;
    triggerNumber <= tn;
    @(posedge clk) triggerPulse <= 1'b0;
  endtask : fire

  task wait_count(input logic [3:0] want);
    int i;
    for (i = 0; i < 3000 && readyCount !== want; i++) @(posedge clk);
    #1 check({12'h000, readyCount}, {12'h000, want});
  endtask : wait_count

  task done_pulse(input logic [3:0] want);
    @(posedge clk) blockDone <= 1'b1;
    @(posedge clk) blockDone <= 1'b0;
    @(posedge clk);
    #1 check({12'h000, readyCount}, {12'h000, want});
  endtask : done_pulse

  task soft_clear();
    @(posedge clk) softReset_n <= 1'b0;
    @(posedge clk) softReset_n <= 1'b1;
    @(posedge clk);
    #1 check({14'h0000, copyOvr, blockOvr}, 16'h0000);
  endtask : soft_clear

  task check_block(input logic [10:0] base, input logic [47:0] ts, input logic [26:0] tn, input logic [10:0] n);
    logic [15:0] d;
    logic [12:0] prev;
    int i;
    for (i = 0; i < 4; i++) begin
      read_sec(base + 11'(i), d);
      check(d, {4'h8, ts[47 - 12 * i -: 12]});
    end
    read_sec(base + 11'h004, d);
    check(d, {3'h2, tn[26:14]});
    read_sec(base + 11'h005, d);
    check(d, {2'h1, tn[13:0]});
    for (i = 0; i < n; i++) begin
      read_sec(base + 11'h006 + 11'(i), d);
      check({13'h0000, d[15:13]}, {13'h0000, (i == n - 1) ? 3'h1 : 3'h0});
      if (i > 0) check({15'h0000, (d[12:0] - prev) inside {13'h0001, 13'h0002, 13'h0003}}, 16'h0001);
      prev = d[12:0];
    end
  endtask : check_block

  task test_blocks();
    fire(48'hABC123456789, 27'h5A5A5A5);
    wait_count(4'h1);
    check({15'h0000, tqFlag}, 16'h0000);
    check_block(11'h000, 48'hABC123456789, 27'h5A5A5A5, 11'h008);
    fire(48'h0123456789AB, 27'h2C3C4C5);
    wait_count(4'h2);
    check({15'h0000, blockOvr}, 16'h0001);
    check_block(11'h00E, 48'h0123456789AB, 27'h2C3C4C5, 11'h008);
    done_pulse(4'h1);
    done_pulse(4'h0);
    done_pulse(4'h0);
    soft_clear();
    $display("test_blocks done");
  endtask : test_blocks

  task test_copy_overrun();
    fire(48'hFEDCBA987654, 27'h7FFFFFF);
    repeat (2) @(posedge clk);
    #1 check({15'h0000, tqFlag}, 16'h0001);
    fire(48'h111111111111, 27'h0000001);
    @(posedge clk);
    #1 check({15'h0000, copyOvr}, 16'h0001);
    wait_count(4'h1);
    check_block(11'h01C, 48'hFEDCBA987654, 27'h7FFFFFF, 11'h008);
    soft_clear();
    done_pulse(4'h0);
    $display("test_copy_overrun done");
  endtask : test_copy_overrun

  // long window across the ring end, consumer holding done high meanwhile
  task test_wrap();
    logic hit;
    int i;
    hit = 1'b0;
    while (cycles < 4000) @(posedge clk);
    winLen <= 11'h0C8;
    blockEnd <= 11'h0CD;
    fire(48'h800000000FFF, 27'h4000000);
    @(posedge clk) blockDone <= 1'b1;
    for (i = 0; i < 3000 && !hit; i++) begin
      @(posedge clk);
      hit = (readyCount == 4'h1);
    end
    blockDone <= 1'b0;
    #1 check({15'h0000, hit}, 16'h0001);
    check_block(11'h02A, 48'h800000000FFF, 27'h4000000, 11'h0C8);
    check({12'h000, readyCount}, 16'h0000);
    $display("test_wrap done");
  endtask : test_wrap

  task complete_run();
    $display("comparisons %0d mismatches %0d", checks, nFail);
    if (nFail == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run

  // reset, then scenarios in turn
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    softReset_n = 1'b1;
    triggerPulse = 1'b0;
    timestamp = 48'h000000000000;
    triggerNumber = 27'h0000000;
    maxReadyBlocks = 4'h2;
    blockDone = 1'b0;
    secReadAddr = 11'h000;
    winLen = 11'h008;
    blockEnd = 11'h00D;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (50) @(posedge clk);
    #1 check({9'h000, readyCount, tqFlag, copyOvr, blockOvr}, 16'h0000);
    test_blocks();
    test_copy_overrun();
    test_wrap();
    complete_run();
  end
endmodule : adc_capture_trigger_window_buffer_bench

//--- capture_buffer_defs.svh
`ifndef CAPTURE_BUFFER_DEFS_SVH
`define CAPTURE_BUFFER_DEFS_SVH

// converter word and capture fifo
`define SAMPLE_BITS 12
`define CAP_WORD_BITS 13
`define CAP_FIFO_DEPTH 15
`define CAP_PTR_BITS 5
// primary ring
`define PRI_LAST_ADDR 12'hFF0
`define PRI_ADDR_BITS 12
// secondary memory
`define SEC_WORDS 2040
`define SEC_ADDR_BITS 11
`define SEC_WORD_BITS 16
`define SEC_HDR_WORDS 11'h006
// trigger queue
`define TQ_WORD_BITS 16
`define TQ_DEPTH 64
`define TQ_ENTRIES_PER_TRIG 3'h7
// tags
`define TAG_QUEUE_TS_FIRST 4'hC
`define TAG_QUEUE_TS_REST 4'h4
`define TAG_QUEUE_PTR 4'h0
`define TAG_SEC_TS 4'h8
`define TAG_SEC_TN_HI 3'h2
`define TAG_SEC_TN_LO 2'h1
`define TAG_SEC_SAMPLE 3'h0
`define TAG_SEC_LAST 3'h1
// timestamp and trigger number
`define TS_BITS 48
`define TN_BITS 27
`define COUNT_BITS 4

`endif

//--- capture_buffer_pkg.sv
package capture_buffer_pkg;

  // copy engine states
  typedef enum logic [2:0] {
    CP_IDLE,
    CP_HEADER,
    CP_COPY,
    CP_DRAIN,
    CP_DONE
  } copy_state_type;

endpackage : capture_buffer_pkg

//--- converter_model.sv
`timescale 1ns/10ps
// ==========================================
// converter: free clock, counting words
module converter_model (
  output logic converterOutputClock,
  output logic [11:0] converterSample,
  output logic converterOverflow
);
  logic [12:0] wordCnt;

  // own clock, phase unrelated to main clock
  initial begin
    converterOutputClock = 1'b0;
    wordCnt = 13'h0000;
    #1.7;
    forever #3 converterOutputClock = ~converterOutputClock;
  end

  always @(posedge converterOutputClock) wordCnt <= wordCnt + 13'h0001;
  assign {converterOverflow, converterSample} = wordCnt;
endmodule : converter_model
